// ---- hw/ptso_trace.sv ----
// Purpose: Per-instruction status codes and trace data nibbles, plus debug bus access
// Assumes: Core presents one retired instruction per accepted cycle
// Notes: Data nibbles leave least significant first, one per clock
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
module ptso_trace
    import ptso_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic instr_valid,
    output logic instr_ready,
    input wire logic [3:0] instr_class,
    input wire logic instr_taken,
    input wire logic src_is_mem,
    input wire logic dst_is_mem,
    input wire logic [1:0] op_size,
    input wire logic [31:0] src_data,
    input wire logic [31:0] dst_data,
    input wire logic [31:0] target_addr,
    input wire logic [1:0] target_size,
    input wire logic [3:0] breakpoint_status_field,
    output logic [3:0] processor_status_code,
    output logic [3:0] trace_data_port,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [31:0] cmd_addr,
    input wire logic [31:0] cmd_wdata,
    output logic cmd_done,
    output logic [31:0] cmd_rdata,
    input wire logic core_bus_idle,
    input wire logic [31:0] lb_rdata,
    output logic fetch_stall,
    output logic dbg_bus_own,
    output logic [31:0] lb_addr,
    output logic [31:0] lb_wdata,
    output logic lb_we
);

    typedef struct packed {
        ptso_trace_state_type st;
        logic ready;
        logic [3:0] psc;
        logic [3:0] tdp;
        logic last;
        logic idx;
        logic [2:0] nib;
        logic [1:0][3:0] code;
        logic [1:0][31:0] data;
        logic [1:0] mode;
        logic branch_target_display_enable;
        logic [31:0] rdata;
    } ptso_trace_reg_type;

    ptso_trace_reg_type q;
    ptso_trace_reg_type d;
    ptso_class_type cls;
    ptso_bus_if bus ();

    assign cls = ptso_class_type'(instr_class);

    // Operand code from access size
    function automatic logic [3:0] size_code(input logic [1:0] sz);
        case (sz)
            SZ_BYTE: size_code = PSC_BYTE1;
            SZ_WORD: size_code = PSC_BYTE2;
            default: size_code = PSC_BYTE4;
        endcase
    endfunction : size_code

    // Index of the last nibble of an entry carrying this code
    function automatic logic [2:0] last_nib(input logic [3:0] c);
        case (c)
            PSC_BYTE1: last_nib = 3'd1;
            PSC_BYTE2: last_nib = 3'd3;
            PSC_BYTE3: last_nib = 3'd5;
            default: last_nib = 3'd7;
        endcase
    endfunction : last_nib

    always_comb begin
        logic [1:0] n;
        logic show_tgt;
        logic show_src;
        logic show_dst;
        logic [31:0] shifted;
        n = 2'd0;
        show_tgt = 1'b0;
        show_src = 1'b0;
        show_dst = 1'b0;
        shifted = '0;
        d = q;
        d.psc = PSC_IDLE;
        d.tdp = breakpoint_status_field;
        d.rdata = '0;
        if (reg_wr && reg_addr == OFS_DEBUG_CONFIG_STATUS_WORD) begin
            d.mode = reg_wdata[FLD_MODE_LSB +: 2];
            d.branch_target_display_enable = reg_wdata[FLD_BRANCH_TARGET];
        end
        if (reg_rd) begin
            case (reg_addr)
                OFS_DEBUG_CONFIG_STATUS_WORD:
                    d.rdata = {29'h0, q.branch_target_display_enable, q.mode};
                OFS_TRACE_STATUS:
                    d.rdata = {26'h0, bus.busy, q.st == TS_EMIT, breakpoint_status_field};
                default: d.rdata = '0;
            endcase
        end
        case (q.st)
            TS_IDLE: begin
                if (instr_valid) begin
                    case (cls)
                        CLS_BCOND: d.psc = instr_taken ? PSC_TAKEN : PSC_SEQ;
                        CLS_BRANCH, CLS_CALL: d.psc = PSC_TAKEN;
                        default: d.psc = PSC_SEQ;
                    endcase
                    show_tgt = q.branch_target_display_enable && (cls == CLS_BRANCH
                        || cls == CLS_CALL || (cls == CLS_BCOND && instr_taken));
                    show_src = src_is_mem && q.mode[MODE_READ_BIT] && (cls == CLS_BITMOD
                        || cls == CLS_BITTEST || cls == CLS_RMW || cls == CLS_RDREG);
                    show_dst = dst_is_mem && q.mode[MODE_WRITE_BIT] && (cls == CLS_BITMOD
                        || cls == CLS_RMW || cls == CLS_CLEAR || cls == CLS_CALL);
                    if (show_tgt) begin
                        d.code[n[0]] = target_size == 2'd0 ? PSC_BYTE2 :
                            (target_size == 2'd1 ? PSC_BYTE3 : PSC_BYTE4);
                        d.data[n[0]] = target_addr;
                        n = n + 2'd1;
                    end
                    if (show_src && !show_tgt) begin
                        d.code[n[0]] = (cls == CLS_BITMOD || cls == CLS_BITTEST) ?
                            PSC_BYTE1 : size_code(op_size);
                        d.data[n[0]] = src_data;
                        n = n + 2'd1;
                    end
                    if (show_dst) begin
                        d.code[n[0]] = cls == CLS_BITMOD ? PSC_BYTE1 :
                            (cls == CLS_CALL ? PSC_BYTE4 : size_code(op_size));
                        d.data[n[0]] = dst_data;
                        n = n + 2'd1;
                    end
                    if (n != 2'd0) begin
                        d.st = TS_EMIT;
                        d.ready = 1'b0;
                        d.last = n[1];
                        d.idx = 1'b0;
                        d.nib = 3'd0;
                    end
                end
            end
            TS_EMIT: begin
                shifted = q.data[q.idx] >> {q.nib, 2'b00};
                d.psc = q.nib == 3'd0 ? q.code[q.idx] : PSC_IDLE;
                d.tdp = shifted[3:0];
                if (q.nib == last_nib(q.code[q.idx])) begin
                    d.nib = 3'd0;
                    d.idx = 1'b1;
                    if (q.idx == q.last) begin
                        d.st = TS_IDLE;
                        d.ready = 1'b1;
                    end
                end else begin
                    d.nib = q.nib + 3'd1;
                end
            end
            default: begin
                d.st = TS_IDLE;
                d.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
            q.ready <= 1'b1;
            q.mode <= RST_MODE;
            q.branch_target_display_enable <= RST_BRANCH_TARGET;
        end else begin
            q <= d;
        end
    end

    // Commands pass straight through; the arbiter latches them when idle
    assign bus.req = cmd_valid;
    assign bus.we = cmd_write;
    assign bus.addr = cmd_addr;
    assign bus.wdata = cmd_wdata;

    ptso_bus_arb u_arb (
        .clk(clk),
        .rst(rst),
        .bus(bus),
        .core_bus_idle(core_bus_idle),
        .lb_rdata(lb_rdata)
    );

    assign reg_rdata = q.rdata;
    assign instr_ready = q.ready;
    assign processor_status_code = q.psc;
    assign trace_data_port = q.tdp;
    assign cmd_done = bus.done;
    assign cmd_rdata = bus.rdata;
    assign fetch_stall = bus.fetch_stall;
    assign dbg_bus_own = bus.bus_own;
    assign lb_addr = bus.lb_addr;
    assign lb_wdata = bus.lb_wdata;
    assign lb_we = bus.lb_we;

    logic accept;
    logic was_idle;
    assign accept = instr_valid && instr_ready;
    assign was_idle = q.st == TS_IDLE;

    property p_plain_alone;
        @(posedge clk) disable iff (rst)
        accept && cls == CLS_PLAIN |=> processor_status_code == PSC_SEQ && instr_ready;
    endproperty
    a_plain_alone: assert property (p_plain_alone) else $error("plain op not single code");

    property p_bcond;
        @(posedge clk) disable iff (rst)
        accept && cls == CLS_BCOND |=>
            processor_status_code == ($past(instr_taken) ? PSC_TAKEN : PSC_SEQ);
    endproperty
    a_bcond: assert property (p_bcond) else $error("wrong conditional branch code");

    property p_call_head;
        @(posedge clk) disable iff (rst)
        accept && (cls == CLS_CALL || cls == CLS_BRANCH) |=> processor_status_code == PSC_TAKEN;
    endproperty
    a_call_head: assert property (p_call_head) else $error("branch head not taken code");

    property p_idle_breakpoint_status_field;
        @(posedge clk) disable iff (rst)
        // The port still holds its reset value in the first cycle after reset
        !$past(rst) && $past(was_idle) |-> trace_data_port == $past(breakpoint_status_field);
    endproperty
    a_idle_breakpoint_status_field: assert property (p_idle_breakpoint_status_field) else $error("idle port lacks breakpoint status");

    property p_reg_src_silent;
        @(posedge clk) disable iff (rst)
        accept && cls == CLS_RDREG && !src_is_mem |=> instr_ready;
    endproperty
    a_reg_src_silent: assert property (p_reg_src_silent) else $error("register operand traced");

    property p_bit_test;
        @(posedge clk) disable iff (rst)
        accept && cls == CLS_BITTEST && src_is_mem && q.mode[MODE_READ_BIT] |=>
            processor_status_code == PSC_SEQ ##1 processor_status_code == PSC_BYTE1
            ##1 instr_ready;
    endproperty
    a_bit_test: assert property (p_bit_test) else $error("bit test entry wrong");

    property p_long_read;
        @(posedge clk) disable iff (rst)
        accept && cls == CLS_RDREG && src_is_mem && q.mode[MODE_READ_BIT]
            && op_size == SZ_LONG |=> ##1 processor_status_code == PSC_BYTE4 ##7 instr_ready;
    endproperty
    a_long_read: assert property (p_long_read) else $error("long source entry wrong");

    property p_write_mode_off;
        @(posedge clk) disable iff (rst)
        accept && cls == CLS_CLEAR && !q.mode[MODE_WRITE_BIT] |=> instr_ready;
    endproperty
    a_write_mode_off: assert property (p_write_mode_off) else $error("write shown while off");

    property p_bit_modify;
        @(posedge clk) disable iff (rst)
        accept && cls == CLS_BITMOD && src_is_mem && dst_is_mem && q.mode == 2'h3 |=>
            processor_status_code == PSC_SEQ ##1 processor_status_code == PSC_BYTE1
            ##2 processor_status_code == PSC_BYTE1 ##1 instr_ready;
    endproperty
    a_bit_modify: assert property (p_bit_modify) else $error("bit modify entries wrong");

endmodule : ptso_trace

// ---- hw/ptso_pkg.sv ----
// Purpose: Shared constants and types of the trace status output block
// Assumes: Byte addresses on the register port, 32-bit register data
// Notes: Status codes are four-bit values shown on the status code port
package ptso_pkg;

    localparam int ADDR_W = 4;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_DEBUG_CONFIG_STATUS_WORD = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_TRACE_STATUS = 4'h4;

    // Field positions of the config word
    localparam int FLD_MODE_LSB = 0;
    localparam int FLD_BRANCH_TARGET = 2;

    // Reset values
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic RST_BRANCH_TARGET = 1'b0;

    // Operand display mode bits: bit 0 reads, bit 1 writes
    localparam int MODE_READ_BIT = 0;
    localparam int MODE_WRITE_BIT = 1;

    // Processor status codes
    localparam logic [3:0] PSC_IDLE = 4'h0;
    localparam logic [3:0] PSC_SEQ = 4'h1;
    localparam logic [3:0] PSC_TAKEN = 4'h5;
    localparam logic [3:0] PSC_BYTE1 = 4'h8;
    localparam logic [3:0] PSC_BYTE2 = 4'h9;
    localparam logic [3:0] PSC_BYTE3 = 4'hA;
    localparam logic [3:0] PSC_BYTE4 = 4'hB;

    typedef enum logic [3:0] {
        CLS_PLAIN = 4'h0,
        CLS_BCOND = 4'h1,
        CLS_BRANCH = 4'h2,
        CLS_CALL = 4'h3,
        CLS_BITMOD = 4'h4,
        CLS_BITTEST = 4'h5,
        CLS_RMW = 4'h6,
        CLS_RDREG = 4'h7,
        CLS_CLEAR = 4'h8
    } ptso_class_type;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_WORD = 2'h1,
        SZ_LONG = 2'h2
    } ptso_size_type;

    typedef enum logic [1:0] {
        ARB_IDLE = 2'b00,
        ARB_WAIT = 2'b01,
        ARB_XFER = 2'b11,
        ARB_REL = 2'b10
    } ptso_arb_state_type;

    typedef enum logic {
        TS_IDLE = 1'b0,
        TS_EMIT = 1'b1
    } ptso_trace_state_type;

endpackage : ptso_pkg

// ---- hw/ptso_bus_if.sv ----
// Purpose: Debug memory command path between trace top and bus arbiter
// Assumes: One clock domain
// Notes: Local bus outputs are flops inside the arbiter
`timescale 1ns/1ps
interface ptso_bus_if;
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic done;
    logic busy;
    logic [31:0] rdata;
    logic fetch_stall;
    logic bus_own;
    logic [31:0] lb_addr;
    logic [31:0] lb_wdata;
    logic lb_we;

    modport arb (
        input req, we, addr, wdata,
        output done, busy, rdata, fetch_stall, bus_own, lb_addr, lb_wdata, lb_we
    );
    modport host (
        output req, we, addr, wdata,
        input done, busy, rdata, fetch_stall, bus_own, lb_addr, lb_wdata, lb_we
    );
endinterface : ptso_bus_if

// ---- hw/ptso_bus_arb.sv ----
// Purpose: Borrows the core local bus for one debug memory cycle
// Assumes: Core raises core_bus_idle once fetch is stalled and its cycle ends
// Notes: Requests arriving while busy are ignored
`timescale 1ns/1ps
module ptso_bus_arb
    import ptso_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    ptso_bus_if.arb bus,
    input wire logic core_bus_idle,
    input wire logic [31:0] lb_rdata
);

    typedef struct packed {
        ptso_arb_state_type st;
        logic stall;
        logic own;
        logic we_out;
        logic we;
        logic done;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
    } ptso_arb_reg_type;

    ptso_arb_reg_type q;
    ptso_arb_reg_type d;

    always_comb begin
        d = q;
        d.done = 1'b0;
        case (q.st)
            ARB_IDLE: begin
                if (bus.req) begin
                    d.stall = 1'b1;
                    d.we = bus.we;
                    d.addr = bus.addr;
                    d.wdata = bus.wdata;
                    d.st = ARB_WAIT;
                end
            end
            ARB_WAIT: begin
                // A loop inside one longword may keep the core busy forever
                if (core_bus_idle) begin
                    d.own = 1'b1;
                    d.we_out = q.we;
                    d.st = ARB_XFER;
                end
            end
            ARB_XFER: begin
                d.own = 1'b0;
                d.we_out = 1'b0;
                d.stall = 1'b0;
                d.done = 1'b1;
                if (!q.we) begin
                    d.rdata = lb_rdata;
                end
                d.st = ARB_REL;
            end
            ARB_REL: begin
                d.st = ARB_IDLE;
            end
            default: begin
                d.st = ARB_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign bus.done = q.done;
    assign bus.busy = (q.st != ARB_IDLE);
    assign bus.rdata = q.rdata;
    assign bus.fetch_stall = q.stall;
    assign bus.bus_own = q.own;
    assign bus.lb_addr = q.addr;
    assign bus.lb_wdata = q.wdata;
    // Own flop rather than a gate, so the pin cannot glitch between owned cycles
    assign bus.lb_we = q.we_out;

    property p_own_under_stall;
        @(posedge clk) disable iff (rst) q.own |-> q.stall;
    endproperty
    a_own_under_stall: assert property (p_own_under_stall) else $error("bus owned without stall");

    property p_own_needs_idle;
        @(posedge clk) disable iff (rst) $rose(q.own) |-> $past(core_bus_idle);
    endproperty
    a_own_needs_idle: assert property (p_own_needs_idle) else $error("bus taken while core busy");

    property p_single_cycle;
        @(posedge clk) disable iff (rst) q.own |=> !q.own && !q.stall && q.done;
    endproperty
    a_single_cycle: assert property (p_single_cycle) else $error("bus not returned to core");

    property p_grant_on_idle;
        @(posedge clk) disable iff (rst) q.st == ARB_WAIT && core_bus_idle |=> q.own;
    endproperty
    a_grant_on_idle: assert property (p_grant_on_idle) else $error("idle core bus not taken");

endmodule : ptso_bus_arb

// ---- dv/ptso_core_model.sv ----
// Purpose: Core side of the local bus, answering debug bus requests
// Assumes: Debug cycles are single 32-bit accesses to a small memory
// Notes: Read data outside an owned read cycle is a moving pattern
`timescale 1ns/1ps
module ptso_core_model
    import ptso_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic fetch_stall,
    input wire logic dbg_bus_own,
    input wire logic [31:0] lb_addr,
    input wire logic [31:0] lb_wdata,
    input wire logic lb_we,
    input wire logic tight_loop,
    input wire logic [3:0] idle_delay,
    output logic core_bus_idle,
    output logic [31:0] lb_rdata
);
    logic [3:0] drain_q;
    logic [31:0] noise_q;
    logic [31:0] mem_q [0:15];

    always_ff @(posedge clk) begin
        if (rst) begin
            drain_q <= 4'h0;
            noise_q <= 32'h0000_0000;
            for (int i = 0; i < 16; i++) begin
                mem_q[i] <= 32'h0000_0000;
            end
        end else begin
            noise_q <= noise_q + 32'h3C5A_9617;
            if (!fetch_stall) begin
                drain_q <= 4'h0;
            end else if (drain_q != 4'hF) begin
                drain_q <= drain_q + 4'h1;
            end
            if (dbg_bus_own && lb_we) begin
                mem_q[lb_addr[5:2]] <= lb_wdata;
            end
        end
    end

    // Own cycle must finish first; a loop in one longword never lets go
    assign core_bus_idle = fetch_stall && !tight_loop && (drain_q >= idle_delay);
    // Core traffic takes the lines back, so stale read data never lingers
    assign lb_rdata = (dbg_bus_own && !lb_we) ? mem_q[lb_addr[5:2]] : noise_q;
endmodule : ptso_core_model

// ---- dv/ptso_trace_tb.sv ----
// Purpose: Self-checking bench for the trace status output block
// Assumes: Core model frees the local bus idle_delay clocks after a stall
// Notes: Trace stream checked nibble by nibble, low nibble first
`timescale 1ns/1ps
module ptso_trace_tb
    import ptso_pkg::*;
;
    logic clk, rst, reg_wr, reg_rd, instr_valid, instr_ready, instr_taken, src_is_mem;
    logic dst_is_mem, cmd_valid, cmd_write, cmd_done, core_bus_idle, fetch_stall;
    logic dbg_bus_own, lb_we, tight_loop;
    logic [3:0] reg_addr, instr_class, breakpoint_status_field, idle_delay;
    logic [3:0] processor_status_code, trace_data_port;
    logic [1:0] op_size, target_size;
    logic [31:0] reg_wdata, reg_rdata, src_data, dst_data, target_addr, cmd_addr;
    logic [31:0] cmd_wdata, cmd_rdata, lb_rdata, lb_addr, lb_wdata;
    int n_errors, cmp_count;

    ptso_trace dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .instr_valid, .instr_ready, .instr_class, .instr_taken, .src_is_mem, .dst_is_mem,
        .op_size, .src_data, .dst_data, .target_addr, .target_size, .breakpoint_status_field,
        .processor_status_code, .trace_data_port, .cmd_valid, .cmd_write, .cmd_addr,
        .cmd_wdata, .cmd_done, .cmd_rdata, .core_bus_idle, .lb_rdata, .fetch_stall,
        .dbg_bus_own, .lb_addr, .lb_wdata, .lb_we);
    ptso_core_model u_core (.clk, .rst, .fetch_stall, .dbg_bus_own, .lb_addr, .lb_wdata,
        .lb_we, .tight_loop, .idle_delay, .core_bus_idle, .lb_rdata);

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(what, exp, reg_rdata);
    endtask : reg_read

    task automatic cfg(input logic [1:0] mode, input logic show_target);
        reg_write(OFS_DEBUG_CONFIG_STATUS_WORD, {29'h0, show_target, mode});
    endtask : cfg

    // Flags are {taken, source in memory, destination in memory}
    task automatic trace(input logic [3:0] cls, input logic [2:0] flags,
        input logic [1:0] sz, input logic [1:0] tsz, input logic [3:0] head);
        int i;
        @(posedge clk);
        src_data <= {src_data[3:0], src_data[31:4]};
        {instr_taken, src_is_mem, dst_is_mem} <= flags;
        instr_class <= cls;
        op_size <= sz;
        target_size <= tsz;
        instr_valid <= 1'b1;
        for (i = 0; i < 20; i++) begin
            #1;
            if (instr_ready === 1'b1) break;
            @(posedge clk);
        end
        @(posedge clk);
        instr_valid <= 1'b0;
        if (i == 20) begin
            n_errors++;
            final_report();
        end
        #1;
        chk("head status code", head, processor_status_code);
    endtask : trace

    task automatic entry(input logic [3:0] code, input int nbytes, input logic [31:0] val);
        for (int k = 0; k < 2 * nbytes; k++) begin
            @(posedge clk);
            #1;
            chk("entry status code", (k == 0) ? code : PSC_IDLE, processor_status_code);
            chk("trace nibble", val[4*k +: 4], trace_data_port);
        end
    endtask : entry

    task automatic end_trace();
        @(posedge clk);
        #1;
        chk("idle status code", PSC_IDLE, processor_status_code);
        chk("idle trace port", breakpoint_status_field, trace_data_port);
        chk("instruction ready", 1'b1, instr_ready);
    endtask : end_trace

    task automatic cmd_pulse(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_addr <= a;
        cmd_wdata <= d;
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask : cmd_pulse

    task automatic cmd_wait(input int lim, input logic exp_done);
        int owns;
        logic seen;
        owns = 0;
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(posedge clk);
            #1;
            if (dbg_bus_own === 1'b1) begin
                owns++;
                chk("local bus address", cmd_addr, lb_addr);
                chk("local bus write", cmd_write, lb_we);
            end
            seen = (cmd_done === 1'b1);
        end
        chk("command done", exp_done, seen);
        chk("bus owned cycles", exp_done, owns);
        chk("fetch stall", !exp_done, fetch_stall);
        if (exp_done && !seen) begin
            final_report();
        end
    endtask : cmd_wait

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        n_errors = 0;
        cmp_count = 0;
        rst = 1'b1;
        {reg_wr, reg_rd, instr_valid, instr_taken, src_is_mem, dst_is_mem} = 6'h00;
        {cmd_valid, cmd_write, tight_loop, op_size, target_size} = 7'h00;
        {reg_addr, instr_class, idle_delay} = 12'h000;
        breakpoint_status_field = 4'h5;
        {reg_wdata, cmd_addr, cmd_wdata} = '0;
        src_data = 32'h8765_4321;
        dst_data = 32'h1357_9BDF;
        target_addr = 32'hA5C3_E1F7;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        reg_read(OFS_DEBUG_CONFIG_STATUS_WORD, 32'h0000_0000, "config reset");
        reg_read(OFS_TRACE_STATUS, 32'h0000_0005, "trace status");
        reg_write(OFS_TRACE_STATUS, 32'hFFFF_FFFF);
        reg_write(4'h8, 32'hFFFF_FFFF);
        cfg(2'h3, 1'b1);
        reg_read(OFS_DEBUG_CONFIG_STATUS_WORD, 32'h0000_0007, "config readback");
        reg_read(OFS_TRACE_STATUS, 32'h0000_0005, "status after write");
        reg_read(4'h8, 32'h0000_0000, "unmapped read");
        $display("test registers done");
        cfg(2'h3, 1'b0);
        trace(CLS_PLAIN, 3'b000, SZ_LONG, 2'h0, PSC_SEQ);
        end_trace();
        trace(CLS_RDREG, 3'b000, SZ_LONG, 2'h0, PSC_SEQ);
        end_trace();
        trace(CLS_BITMOD, 3'b011, SZ_LONG, 2'h0, PSC_SEQ);
        entry(PSC_BYTE1, 1, src_data);
        entry(PSC_BYTE1, 1, dst_data);
        end_trace();
        trace(CLS_RMW, 3'b011, SZ_LONG, 2'h0, PSC_SEQ);
        entry(PSC_BYTE4, 4, src_data);
        entry(PSC_BYTE4, 4, dst_data);
        end_trace();
        cfg(2'h1, 1'b0);
        trace(CLS_RDREG, 3'b010, SZ_LONG, 2'h0, PSC_SEQ);
        entry(PSC_BYTE4, 4, src_data);
        end_trace();
        trace(CLS_RDREG, 3'b010, SZ_WORD, 2'h0, PSC_SEQ);
        entry(PSC_BYTE2, 2, src_data);
        end_trace();
        trace(CLS_BITTEST, 3'b011, SZ_BYTE, 2'h0, PSC_SEQ);
        entry(PSC_BYTE1, 1, src_data);
        end_trace();
        trace(CLS_CLEAR, 3'b001, SZ_LONG, 2'h0, PSC_SEQ);
        end_trace();
        cfg(2'h2, 1'b0);
        trace(CLS_RDREG, 3'b010, SZ_LONG, 2'h0, PSC_SEQ);
        end_trace();
        for (int s = 0; s < 3; s++) begin
            trace(CLS_CLEAR, 3'b001, 2'(s), 2'h0, PSC_SEQ);
            entry((s == 0) ? PSC_BYTE1 : (s == 1) ? PSC_BYTE2 : PSC_BYTE4, 1 << s, dst_data);
            end_trace();
        end
        $display("test operands done");
        cfg(2'h0, 1'b0);
        trace(CLS_BCOND, 3'b100, SZ_LONG, 2'h0, PSC_TAKEN);
        end_trace();
        trace(CLS_BCOND, 3'b000, SZ_LONG, 2'h0, PSC_SEQ);
        end_trace();
        trace(CLS_BRANCH, 3'b000, SZ_LONG, 2'h0, PSC_TAKEN);
        end_trace();
        cfg(2'h0, 1'b1);
        breakpoint_status_field <= 4'hA;
        for (int t = 0; t < 3; t++) begin
            trace(CLS_BRANCH, 3'b000, SZ_LONG, 2'(t), PSC_TAKEN);
            entry(PSC_BYTE2 + 4'(t), t + 2, target_addr);
            end_trace();
        end
        cfg(2'h2, 1'b1);
        trace(CLS_CALL, 3'b001, SZ_LONG, 2'h2, PSC_TAKEN);
        entry(PSC_BYTE4, 4, target_addr);
        entry(PSC_BYTE4, 4, dst_data);
        end_trace();
        $display("test branches done");
        // Only memory commands are sent, never core register access
        // Trigger settings are not part of this block, so no load order applies
        @(posedge clk);
        idle_delay <= 4'h3;
        cmd_pulse(1'b1, 32'h0000_0010, 32'hC0DE_5AA5);
        cmd_wait(30, 1'b1);
        // Config is written only while no debug command runs
        cfg(2'h1, 1'b0);
        idle_delay <= 4'hF;
        cmd_pulse(1'b0, 32'h0000_0010, 32'h0000_0000);
        trace(CLS_RDREG, 3'b010, SZ_LONG, 2'h0, PSC_SEQ);
        entry(PSC_BYTE4, 4, src_data);
        end_trace();
        cmd_wait(30, 1'b1);
        chk("command read data", 32'hC0DE_5AA5, cmd_rdata);
        cmd_pulse(1'b1, 32'h0000_0020, 32'h1234_5678);
        cmd_pulse(1'b1, 32'h0000_0020, 32'hBAD0_BAD0);
        cmd_wait(40, 1'b1);
        cmd_pulse(1'b0, 32'h0000_0020, 32'h0000_0000);
        cmd_wait(40, 1'b1);
        chk("dropped command", 32'h1234_5678, cmd_rdata);
        @(posedge clk);
        tight_loop <= 1'b1;
        idle_delay <= 4'h2;
        cmd_pulse(1'b1, 32'h0000_0030, 32'h0000_0030);
        cmd_wait(40, 1'b0);
        reg_read(OFS_TRACE_STATUS, 32'h0000_002A, "bus busy status");
        @(posedge clk);
        tight_loop <= 1'b0;
        cmd_wait(20, 1'b1);
        $display("test debug bus done");
        final_report();
    end
endmodule : ptso_trace_tb
